// File: iob_host.sv
// processor end: sequences control pulses and priority grants
`timescale 1ns/100ps
module iob_host import iob_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  iob_if.host bus_io,
  input wire logic cmd_valid_i,
  input wire logic [CODE_W-1:0] cmd_code_i,
  input wire logic [2:0] cmd_pulse_i,
  input wire logic cmd_status_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic api_en_i,
  input wire logic power_clear_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic skip_o,
  output logic dir_in_o,
  output logic int_req_o,
  output logic trap_valid_o,
  output logic [LVL_W-1:0] trap_level_o,
  output logic [TRAP_W-1:0] trap_addr_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, INSTR, GRANT} iob_host_fsm_type;

  typedef struct packed {
    iob_host_fsm_type fsm;
    logic [PH_W-1:0] ph;
    logic [STEP_W-1:0] step;
    logic [CODE_W-1:0] code;
    logic [2:0] mask;
    logic is_status;
    logic [2:0] pulse;
    logic status_rd;
    logic sync;
    logic pwr_clr;
    logic [DATA_W-1:0] hdata;
    logic hoe_b;
    logic [LVL_N-1:0] grant;
    logic [LVL_N-1:0] chain_en;
    logic [LVL_N-1:0] svc;
    logic [LVL_W-1:0] lvl;
    logic ready;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic skip;
    logic dir_in;
    logic int_req;
    logic trap_valid;
    logic [TRAP_W-1:0] trap_addr;
  } iob_host_state_type;

  localparam iob_host_state_type HOST_RST = '{
    fsm: IDLE, ph: '0, step: '0, code: '0, mask: '0, is_status: 1'h0,
    pulse: '0, status_rd: 1'h0, sync: 1'h0, pwr_clr: 1'h0, hdata: '0,
    hoe_b: 1'h1, grant: '0, chain_en: '0, svc: '0, lvl: '0,
    ready: 1'h0, done: 1'h0, rdata: '0, skip: 1'h0, dir_in: 1'h0,
    int_req: 1'h0, trap_valid: 1'h0, trap_addr: '0
  };

  iob_host_state_type st_r;
  iob_host_state_type st_nxt;
  logic [LVL_N-1:0] pend;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'h0;
    st_nxt.trap_valid = 1'h0;
    st_nxt.pwr_clr = power_clear_i;
    st_nxt.int_req = bus_io.int_req;
    st_nxt.chain_en = {LVL_N{api_en_i}};
    // a level is granted again only after its request dropped
    st_nxt.svc = st_r.svc & bus_io.api_req;
    pend = bus_io.api_req & ~st_r.svc & {LVL_N{api_en_i}};
    unique case (st_r.fsm)
      IDLE: begin
        st_nxt.ready = 1'h1;
        if (|pend) begin
          st_nxt.fsm = GRANT;
          st_nxt.lvl = iob_lowest(pend);
          st_nxt.step = '0;
          st_nxt.ready = 1'h0;
        end else if (cmd_valid_i && st_r.ready) begin
          st_nxt.fsm = INSTR;
          st_nxt.code = cmd_code_i;
          st_nxt.mask = cmd_pulse_i;
          st_nxt.is_status = cmd_status_i;
          // write word placed for the device
          st_nxt.hdata = cmd_wdata_i;
          st_nxt.ph = PH_P1;
          st_nxt.step = '0;
          st_nxt.skip = 1'h0;
          st_nxt.dir_in = 1'h0;
          st_nxt.ready = 1'h0;
        end
      end
      INSTR: begin
        if (st_r.ph == PH_P1 && st_r.step == SAMPLE_STEP) begin
          st_nxt.skip = bus_io.skip_echo;
        end
        // read and status words loaded alike
        if (st_r.ph == PH_P2 && st_r.step == SAMPLE_STEP) begin
          st_nxt.rdata = bus_io.bus_data;
          st_nxt.dir_in = bus_io.rd_dir;
        end
        if (st_r.step == PHASE_END) begin
          st_nxt.step = '0;
          if (st_r.ph == PH_P4) begin
            st_nxt.fsm = IDLE;
            st_nxt.done = 1'h1;
          end else begin
            st_nxt.ph = st_r.ph + PH_W'(1);
          end
        end else begin
          st_nxt.step = st_r.step + STEP_W'(1);
        end
      end
      GRANT: begin
        if (st_r.step == SAMPLE_STEP) begin
          st_nxt.trap_addr = bus_io.trap_bus;
          st_nxt.trap_valid = !bus_io.trap_oe_b;
          st_nxt.svc[st_r.lvl] = 1'h1;
        end
        if (st_r.step == PHASE_END) begin
          st_nxt.fsm = IDLE;
          st_nxt.step = '0;
        end else begin
          st_nxt.step = st_r.step + STEP_W'(1);
        end
      end
    endcase

    // bus strobes derived from the next position
    st_nxt.pulse = '0;
    st_nxt.status_rd = 1'h0;
    st_nxt.sync = 1'h0;
    st_nxt.grant = '0;
    st_nxt.hoe_b = !(st_nxt.fsm == INSTR && st_nxt.ph == PH_P4);
    if (st_nxt.fsm == INSTR && st_nxt.step < PULSE_CYC) begin
      // status read is unaddressed, at pulse two
      if (st_nxt.is_status) begin
        st_nxt.status_rd = (st_nxt.ph == PH_P2);
      end else begin
        st_nxt.pulse[st_nxt.ph] = st_nxt.mask[st_nxt.ph];
      end
    end
    // grant and sync framing the trap address
    if (st_nxt.fsm == GRANT && st_nxt.step < PULSE_CYC) begin
      st_nxt.grant[st_nxt.lvl] = 1'h1;
      st_nxt.sync = 1'h1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= HOST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_io.code = st_r.code;
  assign bus_io.pulse = st_r.pulse;
  assign bus_io.status_rd = st_r.status_rd;
  assign bus_io.sync = st_r.sync;
  assign bus_io.pwr_clr = st_r.pwr_clr;
  assign bus_io.host_data = st_r.hdata;
  assign bus_io.host_oe_b = st_r.hoe_b;
  assign bus_io.api_grant = st_r.grant;
  assign bus_io.chain_en_in = st_r.chain_en;
  assign cmd_ready_o = st_r.ready;
  assign done_o = st_r.done;
  assign rdata_o = st_r.rdata;
  assign skip_o = st_r.skip;
  assign dir_in_o = st_r.dir_in;
  assign int_req_o = st_r.int_req;
  assign trap_valid_o = st_r.trap_valid;
  assign trap_level_o = st_r.lvl;
  assign trap_addr_o = st_r.trap_addr;
endmodule

// File: iob_pkg.sv
// constants, field positions and helpers shared by both bus ends
// What this block does
// - act only on matching device code
// - data lines received through input buffers
// - eighteen-bit register captures write data
// - contacts gated onto lines during pulse two
// - flag raises shared interrupt request
// - skip echo only when flag set
// - every interrupt flag is skip testable
// - status read is untargeted pulse-two pulse
// - status read drives one preassigned line
// - status bit unique per device
// - host loads status word like read
// - command words use ordinary data path
// - host drives writes, takes reads
// - four vectored priority levels for peripherals
// - granted device supplies own trap address
// - device always carries priority logic
// - read direction line asserted with data
// - trap address during grant and sync
// - block chain enable while requesting
// - power clear resets all flags, registers
package iob_pkg;
  localparam int DATA_W = 18;
  localparam int CODE_W = 8;
  localparam int DEV_W = 6;
  localparam int SUB_W = 2;
  localparam int LVL_N = 4;
  localparam int LVL_W = 2;
  localparam int TRAP_W = 6;
  localparam int CNT_W = 16;
  localparam int PH_W = 2;
  localparam int STEP_W = 2;

  // control pulse bit positions (pulse 1, 2 and 4)
  localparam int PULSE1_BIT = 0;
  localparam int PULSE2_BIT = 1;
  localparam int PULSE4_BIT = 2;
  localparam logic [PH_W-1:0] PH_P1 = 2'h0;
  localparam logic [PH_W-1:0] PH_P2 = 2'h1;
  localparam logic [PH_W-1:0] PH_P4 = 2'h2;

  // each pulse is held two cycles, then one idle gap cycle
  localparam logic [STEP_W-1:0] PULSE_CYC = 2'h2;
  localparam logic [STEP_W-1:0] SAMPLE_STEP = 2'h1;
  localparam logic [STEP_W-1:0] PHASE_END = 2'h2;

  // subdevice functions
  localparam logic [SUB_W-1:0] SUB_DATA = 2'h0;
  localparam logic [SUB_W-1:0] SUB_FLAG = 2'h1;
  localparam logic [SUB_W-1:0] SUB_CTRL = 2'h2;

  // command and status word fields
  localparam int CLR_EXT_BIT = 0;
  localparam int CLR_TICK_BIT = 1;
  localparam int CTRL_TICK_EN_BIT = 0;
  localparam int ST_EXT_BIT = 0;
  localparam int ST_TICK_BIT = 1;
  localparam int ST_EN_BIT = 2;

  // this device's assignment on the bus
  localparam logic [DEV_W-1:0] DEV_NUM = 6'h21;
  localparam int STATUS_BIT = 5;
  localparam int PRIO_LEVEL = 0;
  localparam logic [TRAP_W-1:0] TRAP_ADDR = 6'h24;

  // interval timer period
  localparam int TICK_US = 200;
  localparam int CLK_MHZ = 125;

  function automatic logic iob_match(input logic [CODE_W-1:0] code,
                                     input logic [SUB_W-1:0] sub);
    iob_match = (code[CODE_W-1:SUB_W] == DEV_NUM) &&
                (code[SUB_W-1:0] == sub);
  endfunction

  function automatic logic [LVL_W-1:0] iob_lowest(
      input logic [LVL_N-1:0] req);
    iob_lowest = '0;
    for (int i = LVL_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        iob_lowest = LVL_W'(i);
      end
    end
  endfunction
endpackage

// File: iob_if.sv
// shared i/o bus between processor controller and one device
`timescale 1ns/100ps
interface iob_if;
  import iob_pkg::*;
  logic [CODE_W-1:0] code;
  logic [2:0] pulse;
  logic status_rd;
  logic sync;
  logic pwr_clr;
  logic [DATA_W-1:0] host_data;
  logic host_oe_b;
  logic [DATA_W-1:0] dev_data;
  logic [DATA_W-1:0] dev_oe_b;
  logic [DATA_W-1:0] bus_data;
  logic rd_dir;
  logic skip_echo;
  logic int_req;
  logic [LVL_N-1:0] api_req;
  logic [LVL_N-1:0] api_grant;
  logic [LVL_N-1:0] chain_en_in;
  logic [LVL_N-1:0] chain_en_out;
  logic [TRAP_W-1:0] trap_addr;
  logic trap_oe_b;
  logic [TRAP_W-1:0] trap_bus;

  // wired-or of every enabled driver, positive logic
  assign bus_data = (host_oe_b ? '0 : host_data) | (dev_data & ~dev_oe_b);
  assign trap_bus = trap_oe_b ? '0 : trap_addr;

  modport dev (
    input code, pulse, status_rd, sync, pwr_clr, bus_data,
    input api_grant, chain_en_in,
    output dev_data, dev_oe_b, rd_dir, skip_echo, int_req,
    output api_req, chain_en_out, trap_addr, trap_oe_b
  );
  modport host (
    output code, pulse, status_rd, sync, pwr_clr, host_data, host_oe_b,
    output api_grant, chain_en_in,
    input bus_data, rd_dir, skip_echo, int_req, api_req, trap_bus,
    input trap_oe_b
  );
endinterface

// File: iob_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module iob_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } iob_sync_state_type;

  iob_sync_state_type st_r;
  iob_sync_state_type st_nxt;

  // s1 feeds s2 only; the filter looks at s2 and s3
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;
endmodule

// File: iob_dev.sv
// device end: decode, data register, contacts, flags, priority logic
`timescale 1ns/100ps
module iob_dev import iob_pkg::*; #(
  parameter int unsigned TICK_CYC = TICK_US * CLK_MHZ
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  iob_if.dev bus_io,
  input wire logic [DATA_W-1:0] contact_i,
  input wire logic flag_set_i,
  output logic [DATA_W-1:0] out_word_o,
  output logic [1:0] flags_o,
  output logic tick_en_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic ext_flag;
    logic tick_flag;
    logic tick_en;
    logic [CNT_W-1:0] tick_cnt;
    logic [DATA_W-1:0] out_word;
    logic [DATA_W-1:0] drv;
    logic [DATA_W-1:0] oe_b;
    logic rd_dir;
    logic skip;
    logic int_req;
    logic [LVL_N-1:0] lvl_req;
    logic [LVL_N-1:0] en_out;
    logic [TRAP_W-1:0] trap;
    logic trap_oe_b;
  } iob_dev_state_type;

  localparam iob_dev_state_type DEV_RST = '{
    ext_flag: 1'h0,
    tick_flag: 1'h0,
    tick_en: 1'h0,
    tick_cnt: '0,
    out_word: '0,
    drv: '0,
    oe_b: '1,
    rd_dir: 1'h0,
    skip: 1'h0,
    int_req: 1'h0,
    lvl_req: '0,
    en_out: '0,
    trap: '0,
    trap_oe_b: 1'h1
  };

  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYC - 1);

  iob_dev_state_type st_r;
  iob_dev_state_type st_nxt;
  logic [DATA_W-1:0] contact_s;
  logic hit_data;
  logic hit_flag;
  logic hit_ctrl;
  logic any_flag;
  logic rd_data;
  logic rd_stat;
  logic granted;

  // ------------------------------------------------------------
  // contact inputs come from switches, not from this clock
  // ------------------------------------------------------------
  iob_sync3 #(
    .W(DATA_W)
  ) u_contact_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .d_i(contact_i),
    .q_o(contact_s)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    hit_data = iob_match(bus_io.code, SUB_DATA);
    hit_flag = iob_match(bus_io.code, SUB_FLAG);
    hit_ctrl = iob_match(bus_io.code, SUB_CTRL);
    any_flag = st_r.ext_flag | st_r.tick_flag;
    rd_data = hit_data && bus_io.pulse[PULSE2_BIT];
    rd_stat = hit_flag && bus_io.pulse[PULSE2_BIT];

    // interval timer posts the tick flag
    if (st_r.tick_en) begin
      if (st_r.tick_cnt == TICK_LAST) begin
        st_nxt.tick_cnt = '0;
      end else begin
        st_nxt.tick_cnt = st_r.tick_cnt + CNT_W'(1);
      end
    end else begin
      st_nxt.tick_cnt = '0;
    end

    // control word on the data lines
    if (hit_ctrl && bus_io.pulse[PULSE4_BIT]) begin
      st_nxt.tick_en = bus_io.bus_data[CTRL_TICK_EN_BIT];
    end

    // clear only by own clear instruction or by bus power clear
    if (hit_flag && bus_io.pulse[PULSE4_BIT]) begin
      if (bus_io.bus_data[CLR_EXT_BIT]) begin
        st_nxt.ext_flag = 1'h0;
      end
      if (bus_io.bus_data[CLR_TICK_BIT]) begin
        st_nxt.tick_flag = 1'h0;
      end
    end
    // a set in the clearing cycle wins, so no event is lost
    if (flag_set_i) begin
      st_nxt.ext_flag = 1'h1;
    end
    if (st_r.tick_en && st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_flag = 1'h1;
    end

    // bus data taken from the line receivers
    if (hit_data && bus_io.pulse[PULSE4_BIT]) begin
      st_nxt.out_word = bus_io.bus_data;
    end

    // contacts gated only during pulse two
    st_nxt.drv = '0;
    st_nxt.oe_b = '1;
    if (rd_data) begin
      st_nxt.drv = contact_s;
      st_nxt.oe_b = '0;
    end else if (rd_stat) begin
      st_nxt.drv[ST_EXT_BIT] = st_r.ext_flag;
      st_nxt.drv[ST_TICK_BIT] = st_r.tick_flag;
      st_nxt.drv[ST_EN_BIT] = st_r.tick_en;
      st_nxt.oe_b = '0;
    end
    // status read drives one line only
    // line index is unique to this device
    if (bus_io.status_rd) begin
      st_nxt.drv[STATUS_BIT] = any_flag;
      st_nxt.oe_b[STATUS_BIT] = 1'h0;
    end
    st_nxt.rd_dir = rd_data || rd_stat;

    // echo only if addressed flag set
    // each interrupt flag has a skip test
    st_nxt.skip = 1'h0;
    if (bus_io.pulse[PULSE1_BIT]) begin
      st_nxt.skip = (hit_data && st_r.ext_flag) ||
                    (hit_flag && st_r.tick_flag) ||
                    (hit_ctrl && any_flag);
    end

    st_nxt.int_req = any_flag;

    st_nxt.lvl_req = '0;
    st_nxt.lvl_req[PRIO_LEVEL] = any_flag;

    st_nxt.en_out = bus_io.chain_en_in;
    if (st_r.lvl_req[PRIO_LEVEL]) begin
      st_nxt.en_out[PRIO_LEVEL] = 1'h0;
    end

    granted = bus_io.api_grant[PRIO_LEVEL] &&
              bus_io.chain_en_in[PRIO_LEVEL] &&
              bus_io.sync && st_r.lvl_req[PRIO_LEVEL];
    st_nxt.trap = granted ? TRAP_ADDR : '0;
    st_nxt.trap_oe_b = !granted;

    // bus power clear restores initial state
    if (bus_io.pwr_clr) begin
      st_nxt = DEV_RST;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= DEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from state
  // ------------------------------------------------------------
  assign bus_io.dev_data = st_r.drv;
  assign bus_io.dev_oe_b = st_r.oe_b;
  assign bus_io.rd_dir = st_r.rd_dir;
  assign bus_io.skip_echo = st_r.skip;
  assign bus_io.int_req = st_r.int_req;
  assign bus_io.api_req = st_r.lvl_req;
  assign bus_io.chain_en_out = st_r.en_out;
  assign bus_io.trap_addr = st_r.trap;
  assign bus_io.trap_oe_b = st_r.trap_oe_b;
  assign out_word_o = st_r.out_word;
  assign flags_o = {st_r.tick_flag, st_r.ext_flag};
  assign tick_en_o = st_r.tick_en;
endmodule

// File: iob_asserts.sv
// concurrent checks on the shared bus between host and device ends
`timescale 1ns/100ps
module iob_asserts import iob_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [CODE_W-1:0] code,
  input wire logic [2:0] pulse,
  input wire logic status_rd,
  input wire logic sync,
  input wire logic pwr_clr,
  input wire logic [DATA_W-1:0] bus_data,
  input wire logic [DATA_W-1:0] dev_oe_b,
  input wire logic rd_dir,
  input wire logic skip_echo,
  input wire logic int_req,
  input wire logic [LVL_N-1:0] api_req,
  input wire logic [LVL_N-1:0] api_grant,
  input wire logic [LVL_N-1:0] chain_en_in,
  input wire logic [LVL_N-1:0] chain_en_out,
  input wire logic [TRAP_W-1:0] trap_addr,
  input wire logic trap_oe_b
);
  localparam logic [DATA_W-1:0] ST_LINE = DATA_W'(1) << STATUS_BIT;
  logic hit;
  logic clr_cmd;
  assign hit = code[CODE_W-1:SUB_W] == DEV_NUM;
  assign clr_cmd = hit && code[SUB_W-1:0] == SUB_FLAG && pulse[PULSE4_BIT];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------
  foreign_quiet_a: assert property (|pulse && !status_rd && !hit
    |=> &dev_oe_b && !skip_echo && !rd_dir) else $error("foreign code answered");
  skip_cause_a: assert property (skip_echo
    |-> $past(pulse[PULSE1_BIT] && hit) && int_req) else $error("stray skip");
  any_skip_a: assert property (pulse[PULSE1_BIT] && hit && int_req &&
    code[SUB_W-1:0] == SUB_CTRL |=> skip_echo) else $error("flag not skippable");
  read_drive_a: assert property (pulse[PULSE2_BIT] && hit &&
    code[SUB_W-1:0] == SUB_DATA |=> rd_dir && dev_oe_b == '0)
    else $error("contacts not driven");
  dir_cause_a: assert property (rd_dir
    |-> $past(pulse[PULSE2_BIT] && hit || status_rd)) else $error("stray dir");
  status_line_a: assert property ($past(status_rd)
    |-> &(dev_oe_b | ST_LINE) && bus_data[STATUS_BIT] == int_req)
    else $error("bad status line");
  int_api_a: assert property (api_req == (LVL_N'(int_req) << PRIO_LEVEL))
    else $error("requests disagree");
  int_hold_a: assert property ($fell(int_req) |-> $past(clr_cmd) ||
    $past(clr_cmd, 2) || $past(pwr_clr) || $past(pwr_clr, 2))
    else $error("request dropped without clear");
  pwr_clear_a: assert property (pwr_clr
    |=> !int_req && api_req == '0 && trap_oe_b) else $error("power clear missed");
  chain_block_a: assert property (api_req[PRIO_LEVEL] &&
    $past(api_req[PRIO_LEVEL]) |-> !chain_en_out[PRIO_LEVEL])
    else $error("enable passed while requesting");
  chain_pass_a: assert property ($stable(chain_en_in) && !api_req[0] &&
    $past(!api_req[0]) |-> chain_en_out == chain_en_in)
    else $error("enable not passed");
  trap_give_a: assert property (sync && api_grant[PRIO_LEVEL] &&
    chain_en_in[PRIO_LEVEL] && api_req[PRIO_LEVEL]
    |=> !trap_oe_b && trap_addr == TRAP_ADDR) else $error("no trap address");
  trap_cause_a: assert property (!trap_oe_b
    |-> $past(sync && api_grant[PRIO_LEVEL])) else $error("stray trap drive");
  skip_c: cover property (skip_echo);
  status_c: cover property (status_rd);
  trap_c: cover property (!trap_oe_b);
  read_c: cover property (rd_dir);
endmodule

// File: iob_tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module iob_tb_top import iob_pkg::*;;
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [2:0] pm;
    logic st;
    logic [DATA_W-1:0] wd;
    logic set;
    logic [DATA_W-1:0] rd;
    logic sk;
    logic ir;
    logic [DATA_W-1:0] ow;
  } iob_row_type;
  localparam logic N = 1'b0;
  localparam logic Y = 1'b1;
  localparam logic [DEV_W-1:0] D = DEV_NUM;
  localparam logic [DEV_W-1:0] F = DEV_NUM ^ 6'h01;
  localparam logic [DATA_W-1:0] CON = 18'h2_A5C3;
  localparam logic [DATA_W-1:0] W1 = 18'h3_C0F1;
  localparam logic [DATA_W-1:0] W2 = 18'h0_0FF0;
  localparam logic [DATA_W-1:0] ST = DATA_W'(1) << STATUS_BIT;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [CODE_W-1:0] cmd_code_i = '0;
  logic [2:0] cmd_pulse_i = '0;
  logic cmd_status_i = 1'b0;
  logic [DATA_W-1:0] cmd_wdata_i = '0;
  logic api_en_i = 1'b0;
  logic power_clear_i = 1'b0;
  logic [DATA_W-1:0] contact_i = CON;
  logic flag_set_i = 1'b0;
  logic cmd_ready_o, done_o, skip_o, dir_in_o, int_req_o, trap_valid_o;
  logic tick_en_o;
  logic [DATA_W-1:0] rdata_o, out_word_o;
  logic [1:0] flags_o;
  logic [LVL_W-1:0] trap_level_o;
  logic [TRAP_W-1:0] trap_addr_o;
  int fails = 0;
  int n_compared = 0;
  int n;
  iob_row_type r;
  iob_row_type rows[$];

  always #4 clk_sys_i = ~clk_sys_i;
  iob_if bus_if();
  iob_host u_iob_host (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .bus_io(bus_if), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_pulse_i(cmd_pulse_i), .cmd_status_i(cmd_status_i),
    .cmd_wdata_i(cmd_wdata_i), .api_en_i(api_en_i),
    .power_clear_i(power_clear_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .rdata_o(rdata_o), .skip_o(skip_o),
    .dir_in_o(dir_in_o), .int_req_o(int_req_o),
    .trap_valid_o(trap_valid_o), .trap_level_o(trap_level_o),
    .trap_addr_o(trap_addr_o));
  // short timer period keeps the run brief
  iob_dev #(.TICK_CYC(8)) u_iob_dev (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .bus_io(bus_if), .contact_i(contact_i),
    .flag_set_i(flag_set_i), .out_word_o(out_word_o), .flags_o(flags_o),
    .tick_en_o(tick_en_o));
  iob_asserts u_iob_asserts (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .code(bus_if.code), .pulse(bus_if.pulse), .status_rd(bus_if.status_rd),
    .sync(bus_if.sync), .pwr_clr(bus_if.pwr_clr),
    .bus_data(bus_if.bus_data), .dev_oe_b(bus_if.dev_oe_b),
    .rd_dir(bus_if.rd_dir), .skip_echo(bus_if.skip_echo),
    .int_req(bus_if.int_req), .api_req(bus_if.api_req),
    .api_grant(bus_if.api_grant), .chain_en_in(bus_if.chain_en_in),
    .chain_en_out(bus_if.chain_en_out), .trap_addr(bus_if.trap_addr),
    .trap_oe_b(bus_if.trap_oe_b));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // inputs move 1 ns after the edge, never on it
  task automatic ticks(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic do_reset;
    rst_b_i = 1'b0;
    ticks(6);
    check("reset out word", out_word_o, '0);
    check("reset flags", DATA_W'(flags_o), '0);
    check("reset ready", DATA_W'(cmd_ready_o), '0);
    rst_b_i = 1'b1;
  endtask

  // valid held until the edge that samples ready high
  task automatic do_cmd(input iob_row_type c);
    int k;
    cmd_valid_i = 1'b1;
    cmd_code_i = c.code;
    cmd_pulse_i = c.pm;
    cmd_status_i = c.st;
    cmd_wdata_i = c.wd;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 50) begin
      ticks(1);
      k++;
    end
    ticks(1);
    cmd_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 30) begin
      ticks(1);
      k++;
    end
    check("done in time", DATA_W'(k < 30), 18'h0_0001);
  endtask

  task automatic set_flag;
    flag_set_i = 1'b1;
    ticks(1);
    flag_set_i = 1'b0;
    ticks(2);
  endtask

  initial begin
    ticks(20000);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows.push_back('{{D, SUB_DATA}, 3'h4, N, W1, N, '0, N, N, W1});
    rows.push_back('{{D, SUB_DATA}, 3'h2, N, '0, N, CON, N, N, W1});
    rows.push_back('{{D, SUB_DATA}, 3'h7, N, W2, N, CON, N, N, W2});
    rows.push_back('{{F, SUB_DATA}, 3'h6, N, W1, N, '0, N, N, W2});
    rows.push_back('{{D, SUB_FLAG}, 3'h2, N, '0, N, '0, N, N, W2});
    rows.push_back('{8'h00, 3'h2, Y, '0, N, '0, N, N, W2});
    rows.push_back('{{D, SUB_DATA}, 3'h1, N, '0, Y, '0, Y, Y, W2});
    rows.push_back('{{D, SUB_CTRL}, 3'h1, N, '0, N, '0, Y, Y, W2});
    rows.push_back('{{D, SUB_FLAG}, 3'h1, N, '0, N, '0, N, Y, W2});
    rows.push_back('{8'h00, 3'h2, Y, '0, N, ST, N, Y, W2});
    rows.push_back('{{D, SUB_FLAG}, 3'h2, N, '0, N, 18'h0_0001, N, Y, W2});
    rows.push_back('{{D, SUB_FLAG}, 3'h4, N, 18'h0_0002, N, '0, N, Y, W2});
    rows.push_back('{{F, SUB_FLAG}, 3'h4, N, 18'h0_0001, N, '0, N, Y, W2});
    rows.push_back('{{D, SUB_FLAG}, 3'h4, N, 18'h0_0001, N, '0, N, N, W2});
    rows.push_back('{{D, SUB_DATA}, 3'h1, N, '0, N, '0, N, N, W2});
    do_reset();
    ticks(4);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.set) begin
        set_flag();
      end
      do_cmd(r);
      ticks(1);
      if (r.pm[1] || r.st) begin
        check("read word", rdata_o, r.rd);
      end
      if (r.pm[0]) begin
        check("skip", DATA_W'(skip_o), DATA_W'(r.sk));
      end
      if (r.pm[1] && !r.st) begin
        check("direction", DATA_W'(dir_in_o), DATA_W'(r.code[7:2] == D));
      end
      check("interrupt", DATA_W'(int_req_o), DATA_W'(r.ir));
      check("out word", out_word_o, r.ow);
    end
    check("idle bus", bus_if.bus_data, '0);
    // priority request, grant and trap
    api_en_i = 1'b1;
    flag_set_i = 1'b1;
    ticks(1);
    flag_set_i = 1'b0;
    n = 0;
    while (trap_valid_o !== 1'b1 && n < 50) begin
      ticks(1);
      n++;
    end
    check("trap address", DATA_W'(trap_addr_o), DATA_W'(TRAP_ADDR));
    check("trap level", DATA_W'(trap_level_o), DATA_W'(PRIO_LEVEL));
    check("chain held", DATA_W'(bus_if.chain_en_out), 18'h0_000E);
    do_cmd('{{D, SUB_FLAG}, 3'h4, N, 18'h0_0001, N, '0, N, N, '0});
    ticks(3);
    check("chain passed", DATA_W'(bus_if.chain_en_out), 18'h0_000F);
    check("request cleared", DATA_W'(int_req_o), '0);
    api_en_i = 1'b0;
    // interval timer raises its own flag
    do_cmd('{{D, SUB_CTRL}, 3'h4, N, 18'h0_0001, N, '0, N, N, '0});
    ticks(20);
    check("timer on", DATA_W'(tick_en_o), 18'h0_0001);
    check("timer flag", DATA_W'(flags_o), 18'h0_0002);
    do_cmd('{{D, SUB_CTRL}, 3'h4, N, '0, N, '0, N, N, '0});
    // power clear with flags up and a word held
    do_cmd('{{D, SUB_DATA}, 3'h4, N, W1, N, '0, N, N, '0});
    set_flag();
    power_clear_i = 1'b1;
    ticks(3);
    power_clear_i = 1'b0;
    ticks(2);
    check("clear word", out_word_o, '0);
    check("clear flags", DATA_W'(flags_o), '0);
    check("clear timer", DATA_W'(tick_en_o), '0);
    check("clear request", DATA_W'(int_req_o), '0);
    do_cmd('{{D, SUB_DATA}, 3'h4, N, W2, N, '0, N, N, '0});
    check("write after clear", out_word_o, W2);
    // switches move while idle; the read must see the new word
    contact_i = W2;
    do_cmd('{{D, SUB_DATA}, 3'h2, N, '0, N, W2, N, N, '0});
    ticks(1);
    check("contact change", rdata_o, W2);
    do_reset();
    ticks(2);
    tally_and_finish();
  end
endmodule
